//--- rtl/rgd_cmd.sv
// custom command handler: clear read guard and set/clear alarm flag
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - clear command clears both read guards
// - decode clear frame: opcode, password, handle, crc
// - unscramble password with doubled rn16
// - crc spans opcode through handle
// - success reply: 0, handle, crc
// - replies always use extended preamble
// - failure backscatters an error code instead
// - alarm command runs only when secured
// - alarm ignored: zero password, bad crc/handle
// - decode alarm frame: opcode, action, handle, crc
// - alarm flag follows the action bit
// - alarm query enabled from next power-up
// - select plus query remains an alternative
// - alarm: silent, arbitrate states fall back
// - secured: good handle replies, bad stays silent
// - clear ignored when access password zero
// - flags live at bits 15, 14, 13
module rgd_cmd #(
  parameter int unsigned TIMEOUT_CYC = rgd_pkg::REPLY_WINDOW_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // register bus
  input wire rgd_pkg::rgd_apb_req_t apb_i,
  output rgd_pkg::rgd_apb_rsp_t apb_o,
  // demodulated reader frames and tag context
  input wire rgd_pkg::rgd_rx_t rx_i,
  input wire rgd_pkg::rgd_tag_state_t tag_state_i,
  input wire logic [15:0] handle_i,
  input wire logic [15:0] rn16_i,
  input wire logic reqrn_i,
  // backscatter bits
  output rgd_pkg::rgd_tx_t tx_o,
  input wire logic tx_ready_i,
  // non-volatile flag store
  output rgd_pkg::rgd_nvm_req_t nvm_o,
  input wire logic nvm_done_i,
  input wire logic nvm_err_i,
  input wire rgd_pkg::rgd_flags_t nvm_flags_i,
  // effects on the tag
  output logic goto_arb_o,
  output rgd_pkg::rgd_flags_t flags_o,
  output logic alarm_query_en_o
);

  localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYC - 1);

  typedef struct packed {
    rgd_pkg::rgd_fsm_t fsm;
    logic fsync;
    logic [rgd_pkg::RX_W-1:0] rx_sr;
    logic [6:0] rx_cnt;
    logic [rgd_pkg::TX_W-1:0] tx_sr;
    logic [4:0] tx_cnt;
    logic txv;
    logic tx_last;
    logic ext_pre;
    logic [TW-1:0] tmo;
    rgd_pkg::rgd_nvm_req_t nvm;
    logic goto_arb;
    rgd_pkg::rgd_flags_t flags;
    logic alarm_en;
    logic boot;
    logic ctrl_en;
    logic [31:0] apw;
    rgd_pkg::rgd_apb_rsp_t apb;
    rgd_pkg::rgd_res_t last_res;
    logic [7:0] ok_cnt;
    logic [7:0] ign_cnt;
    logic [7:0] err_cnt;
  } rgd_st_t;

  rgd_st_t st_r;
  rgd_st_t st_nxt;

  logic rx_crc_init;
  logic rx_crc_en;
  logic [15:0] rx_crc;
  logic tx_crc_init;
  logic tx_crc_en;
  logic [15:0] tx_crc;

  logic [15:0] rx_handle;
  logic [31:0] rx_pw;
  logic is_clear;
  logic is_alarm;
  logic crc_ok;
  logic hdl_ok;
  logic tx_take;

  assign is_clear = (st_r.rx_cnt == rgd_pkg::LEN_CLEAR_GUARD) &&
                    (st_r.rx_sr[rgd_pkg::POS_OP_CLEAR +: 16] == rgd_pkg::OP_CLEAR_GUARD);
  assign is_alarm = (st_r.rx_cnt == rgd_pkg::LEN_SET_ALARM) &&
                    (st_r.rx_sr[rgd_pkg::POS_OP_ALARM +: 16] == rgd_pkg::OP_SET_ALARM);
  assign crc_ok = (rx_crc == rgd_pkg::CRC_RESIDUE);
  assign rx_handle = st_r.rx_sr[rgd_pkg::POS_HANDLE +: 16];
  assign rx_pw = rgd_pkg::unscramble(st_r.rx_sr[rgd_pkg::POS_PASSWORD +: 32], rn16_i);
  assign hdl_ok = (rx_handle == handle_i);
  assign tx_take = st_r.txv && tx_ready_i;

  rgd_crc16 u_rx_crc (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .init_i(rx_crc_init),
    .en_i(rx_crc_en),
    .bit_i(rx_i.data),
    .crc_o(rx_crc)
  );

  rgd_crc16 u_tx_crc (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .init_i(tx_crc_init),
    .en_i(tx_crc_en),
    .bit_i(st_r.tx_sr[rgd_pkg::TX_W-1]),
    .crc_o(tx_crc)
  );

  always_comb begin
    logic commit;
    logic ours;
    rgd_pkg::rgd_flags_t nf;
    commit = 1'b0;
    ours = 1'b0;
    nf = st_r.flags;
    st_nxt = st_r;
    st_nxt.goto_arb = 1'b0;
    st_nxt.apb.pready = 1'b0;
    rx_crc_init = 1'b0;
    rx_crc_en = 1'b0;
    tx_crc_init = 1'b0;
    tx_crc_en = 1'b0;

    // alarm query follows the flag as found at power-up
    if (st_r.boot) begin
      st_nxt.boot = 1'b0;
      st_nxt.flags = nvm_flags_i;
      st_nxt.alarm_en = nvm_flags_i.alarm;
    end

    // apb slave: one wait state, read data registered
    if (apb_i.psel && apb_i.penable && !st_r.apb.pready) begin
      st_nxt.apb.pready = 1'b1;
      st_nxt.apb.pslverr = 1'b0;
      st_nxt.apb.prdata = 32'h0000_0000;
      case (apb_i.paddr)
        rgd_pkg::REG_CTRL: st_nxt.apb.prdata[rgd_pkg::CTRL_EN_BIT] = st_r.ctrl_en;
        rgd_pkg::REG_ACCESS_PW: st_nxt.apb.prdata = st_r.apw;
        rgd_pkg::REG_CONFIG: begin
          // flag positions in the configuration word
          st_nxt.apb.prdata[rgd_pkg::CFG_ALARM_BIT] = st_r.flags.alarm;
          st_nxt.apb.prdata[rgd_pkg::CFG_IDENT_GUARD_BIT] = st_r.flags.ident_guard;
          st_nxt.apb.prdata[rgd_pkg::CFG_CODE_GUARD_BIT] = st_r.flags.code_guard;
        end
        rgd_pkg::REG_STATUS: begin
          st_nxt.apb.prdata[rgd_pkg::STAT_OK_LSB +: 8] = st_r.ok_cnt;
          st_nxt.apb.prdata[rgd_pkg::STAT_IGN_LSB +: 8] = st_r.ign_cnt;
          st_nxt.apb.prdata[rgd_pkg::STAT_ERR_LSB +: 8] = st_r.err_cnt;
          st_nxt.apb.prdata[rgd_pkg::STAT_RES_LSB +: 2] = st_r.last_res;
        end
        default: st_nxt.apb.pslverr = 1'b1;
      endcase
    end
    if (apb_i.psel && apb_i.penable && st_r.apb.pready && apb_i.pwrite && !st_r.apb.pslverr) begin
      if (apb_i.paddr == rgd_pkg::REG_CTRL) begin
        st_nxt.ctrl_en = apb_i.pwdata[rgd_pkg::CTRL_EN_BIT];
      end
      if (apb_i.paddr == rgd_pkg::REG_ACCESS_PW) begin
        st_nxt.apw = apb_i.pwdata;
      end
    end

    case (st_r.fsm)
      rgd_pkg::S_IDLE: begin
        if (rx_i.sof) begin
          st_nxt.fsm = rgd_pkg::S_RX;
          st_nxt.fsync = rx_i.fsync;
          st_nxt.rx_cnt = 7'h00;
          rx_crc_init = 1'b1;
        end
      end
      rgd_pkg::S_RX: begin
        if (rx_i.valid) begin
          st_nxt.rx_sr = {st_r.rx_sr[rgd_pkg::RX_W-2:0], rx_i.data};
          // saturate so overlong frames never alias a short one
          if (st_r.rx_cnt != 7'h7F) begin
            st_nxt.rx_cnt = st_r.rx_cnt + 7'h01;
          end
          rx_crc_en = 1'b1;
        end
        if (rx_i.eof) begin
          st_nxt.fsm = rgd_pkg::S_EVAL;
        end
      end
      rgd_pkg::S_EVAL: begin
        st_nxt.fsm = rgd_pkg::S_IDLE;
        ours = (is_clear || is_alarm) && st_r.ctrl_en;
        // frame-sync start expected; bad crc ignored
        if (ours && crc_ok && st_r.fsync && (st_r.apw != 32'h0000_0000)) begin
          case (tag_state_i)
            rgd_pkg::TAG_ARBITRATE, rgd_pkg::TAG_REPLY, rgd_pkg::TAG_ACKNOWLEDGED: begin
              st_nxt.goto_arb = 1'b1;
            end
            rgd_pkg::TAG_OPEN, rgd_pkg::TAG_SECURED: begin
              if (is_clear && hdl_ok) begin
                if (rx_pw != st_r.apw) begin
                  st_nxt.goto_arb = 1'b1;
                end else if (reqrn_i) begin
                  commit = 1'b1;
                  nf.ident_guard = 1'b0;
                  nf.code_guard = 1'b0;
                end
              end
              if (is_alarm && hdl_ok && (tag_state_i == rgd_pkg::TAG_SECURED)) begin
                commit = 1'b1;
                nf.alarm = st_r.rx_sr[rgd_pkg::POS_ACTION];
              end
            end
            default: begin
            end
          endcase
        end
        if (commit) begin
          st_nxt.fsm = rgd_pkg::S_COMMIT;
          st_nxt.nvm.req = 1'b1;
          st_nxt.nvm.flags = nf;
          st_nxt.tmo = '0;
        end else if (ours) begin
          st_nxt.last_res = rgd_pkg::RES_IGNORED;
          st_nxt.ign_cnt = st_r.ign_cnt + 8'h01;
        end
      end
      rgd_pkg::S_COMMIT: begin
        st_nxt.tmo = st_r.tmo + TW'(1);
        // reply once the store answers with done or error, or once the timeout runs out
        if (nvm_done_i || nvm_err_i || (st_r.tmo == TMO_LAST)) begin
          st_nxt.nvm.req = 1'b0;
          st_nxt.fsm = rgd_pkg::S_TX_DATA;
          st_nxt.txv = 1'b1;
          // extended preamble regardless of round setting
          st_nxt.ext_pre = 1'b1;
          tx_crc_init = 1'b1;
          if (nvm_done_i) begin
            st_nxt.flags = st_r.nvm.flags;
            st_nxt.tx_sr = {1'b0, handle_i, 8'h00};
            st_nxt.tx_cnt = rgd_pkg::LEN_REPLY_OK;
            st_nxt.last_res = rgd_pkg::RES_OK;
            st_nxt.ok_cnt = st_r.ok_cnt + 8'h01;
          end else begin
            // error code instead of success reply
            st_nxt.tx_sr = {1'b1, rgd_pkg::ERR_CODE_GENERIC, handle_i};
            st_nxt.tx_cnt = rgd_pkg::LEN_REPLY_ERR;
            st_nxt.last_res = rgd_pkg::RES_ERROR;
            st_nxt.err_cnt = st_r.err_cnt + 8'h01;
          end
        end
      end
      rgd_pkg::S_TX_DATA: begin
        if (tx_take) begin
          tx_crc_en = 1'b1;
          st_nxt.tx_sr = {st_r.tx_sr[rgd_pkg::TX_W-2:0], 1'b0};
          st_nxt.tx_cnt = st_r.tx_cnt - 5'h01;
          if (st_r.tx_cnt == 5'h01) begin
            st_nxt.txv = 1'b0;
            st_nxt.fsm = rgd_pkg::S_TX_LOAD;
          end
        end
      end
      rgd_pkg::S_TX_LOAD: begin
        // one idle bit slot lets the crc settle; the modulator must tolerate it
        st_nxt.tx_sr = {~tx_crc, 9'h000};
        st_nxt.tx_cnt = rgd_pkg::CRC_BITS;
        st_nxt.txv = 1'b1;
        st_nxt.fsm = rgd_pkg::S_TX_CRC;
      end
      rgd_pkg::S_TX_CRC: begin
        if (tx_take) begin
          st_nxt.tx_sr = {st_r.tx_sr[rgd_pkg::TX_W-2:0], 1'b0};
          st_nxt.tx_cnt = st_r.tx_cnt - 5'h01;
          st_nxt.tx_last = (st_r.tx_cnt == 5'h02);
          if (st_r.tx_cnt == 5'h01) begin
            st_nxt.txv = 1'b0;
            st_nxt.ext_pre = 1'b0;
            st_nxt.tx_last = 1'b0;
            st_nxt.fsm = rgd_pkg::S_IDLE;
          end
        end
      end
      default: st_nxt.fsm = rgd_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= '0;
      st_r.boot <= 1'b1;
      st_r.ctrl_en <= rgd_pkg::CTRL_EN_RST;
      st_r.apw <= rgd_pkg::ACCESS_PW_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign apb_o = st_r.apb;
  assign tx_o = '{valid: st_r.txv, data: st_r.tx_sr[rgd_pkg::TX_W-1], last: st_r.tx_last,
                  ext_preamble: st_r.ext_pre};
  assign nvm_o = st_r.nvm;
  assign goto_arb_o = st_r.goto_arb;
  assign flags_o = st_r.flags;
  assign alarm_query_en_o = st_r.alarm_en;

endmodule : rgd_cmd
`default_nettype wire

//--- rtl/rgd_crc16.sv
// serial crc-16 engine, one bit per clock
`timescale 1ns/10ps
`default_nettype none
module rgd_crc16 (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // control and data
  input wire logic init_i,
  input wire logic en_i,
  input wire logic bit_i,
  // result
  output logic [15:0] crc_o
);

  typedef struct packed {
    logic [15:0] crc;
  } rgd_crc_st_t;

  rgd_crc_st_t st_r;
  rgd_crc_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (init_i) begin
      st_nxt.crc = rgd_pkg::CRC_PRESET;
    end else if (en_i) begin
      st_nxt.crc = rgd_pkg::crc16_step(st_r.crc, bit_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= '{crc: rgd_pkg::CRC_PRESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign crc_o = st_r.crc;

endmodule : rgd_crc16
`default_nettype wire

//--- rtl/rgd_pkg.sv
// constants, types and helpers shared by the read-guard and alarm-flag command handler
package rgd_pkg;

  // timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned REPLY_WINDOW_MS = 20;
  localparam int unsigned REPLY_WINDOW_CYC = (CLK_HZ / 1000) * REPLY_WINDOW_MS;

  // command opcodes and frame lengths in bits
  localparam logic [15:0] OP_CLEAR_GUARD = 16'hE002;
  localparam logic [15:0] OP_SET_ALARM = 16'hE003;
  localparam logic [6:0] LEN_CLEAR_GUARD = 7'h50;
  localparam logic [6:0] LEN_SET_ALARM = 7'h31;

  // field positions inside the receive shift register, counted from the last bit
  localparam int unsigned RX_W = 80;
  localparam int unsigned POS_HANDLE = 16;
  localparam int unsigned POS_PASSWORD = 32;
  localparam int unsigned POS_ACTION = 32;
  localparam int unsigned POS_OP_CLEAR = 64;
  localparam int unsigned POS_OP_ALARM = 33;

  // crc-16: preset, polynomial, good residue
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_RESIDUE = 16'h1D0F;
  localparam logic [4:0] CRC_BITS = 5'h10;

  // replies: header + handle, or header + error code + handle
  localparam int unsigned TX_W = 25;
  localparam logic [4:0] LEN_REPLY_OK = 5'h11;
  localparam logic [4:0] LEN_REPLY_ERR = 5'h19;
  localparam logic [7:0] ERR_CODE_GENERIC = 8'h0F;

  // configuration word bit positions
  localparam int unsigned CFG_ALARM_BIT = 15;
  localparam int unsigned CFG_IDENT_GUARD_BIT = 14;
  localparam int unsigned CFG_CODE_GUARD_BIT = 13;

  // apb register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ACCESS_PW = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [31:0] ACCESS_PW_RST = 32'h0000_0000;
  localparam int unsigned STAT_OK_LSB = 0;
  localparam int unsigned STAT_IGN_LSB = 8;
  localparam int unsigned STAT_ERR_LSB = 16;
  localparam int unsigned STAT_RES_LSB = 24;

  typedef enum logic [2:0] {
    TAG_READY = 3'h0,
    TAG_ARBITRATE = 3'h1,
    TAG_REPLY = 3'h2,
    TAG_ACKNOWLEDGED = 3'h3,
    TAG_OPEN = 3'h4,
    TAG_SECURED = 3'h5,
    TAG_KILLED = 3'h6
  } rgd_tag_state_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_RX = 3'h1,
    S_EVAL = 3'h3,
    S_COMMIT = 3'h2,
    S_TX_DATA = 3'h6,
    S_TX_LOAD = 3'h7,
    S_TX_CRC = 3'h5
  } rgd_fsm_t;

  typedef enum logic [1:0] {
    RES_NONE = 2'h0,
    RES_OK = 2'h1,
    RES_ERROR = 2'h2,
    RES_IGNORED = 2'h3
  } rgd_res_t;

  typedef struct packed {
    logic alarm;
    logic ident_guard;
    logic code_guard;
  } rgd_flags_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rgd_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rgd_apb_rsp_t;

  typedef struct packed {
    logic sof;
    logic fsync;
    logic valid;
    logic data;
    logic eof;
  } rgd_rx_t;

  typedef struct packed {
    logic valid;
    logic data;
    logic last;
    logic ext_preamble;
  } rgd_tx_t;

  typedef struct packed {
    logic req;
    rgd_flags_t flags;
  } rgd_nvm_req_t;

  // one serial crc-16 step, data msb first
  function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic din);
    crc16_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ din) ? CRC_POLY : 16'h0000);
  endfunction : crc16_step

  // undo the password scramble with the doubled rn16
  function automatic logic [31:0] unscramble(input logic [31:0] field, input logic [15:0] rn16);
    unscramble = field ^ {rn16, rn16};
  endfunction : unscramble

endpackage : rgd_pkg

//--- testbench/rgd_cmd_sva.sv
// assertion checker for the guard and alarm command handler
`timescale 1ns/10ps
`default_nettype none
module rgd_cmd_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // watched ports
  input wire rgd_pkg::rgd_apb_req_t apb_i,
  input wire rgd_pkg::rgd_apb_rsp_t apb_o,
  input wire rgd_pkg::rgd_tag_state_t tag_state_i,
  input wire rgd_pkg::rgd_tx_t tx_o,
  input wire logic tx_ready_i,
  input wire rgd_pkg::rgd_nvm_req_t nvm_o,
  input wire logic nvm_done_i,
  input wire logic goto_arb_o,
  input wire rgd_pkg::rgd_flags_t flags_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  apb_wait_a: assert property (apb_i.psel && apb_i.penable && !apb_o.pready |=> apb_o.pready)
    else $error("apb access not answered after one wait state");
  apb_err_a: assert property (apb_o.pready && apb_i.paddr > 8'h0C |-> apb_o.pslverr)
    else $error("unmapped access without error");
  reply_ext_a: assert property (tx_o.valid |-> tx_o.ext_preamble)
    else $error("reply bit without extended preamble");
  commit_first_a: assert property ($rose(tx_o.valid) && !tx_o.data && !$past(tx_o.ext_preamble) |-> $past(nvm_done_i))
    else $error("success reply before the store finished");
  flag_load_a: assert property (nvm_done_i && nvm_o.req |=> flags_o == $past(nvm_o.flags))
    else $error("flags differ from the committed value");
  // only a finished write or a power-up may move the flags
  flag_hold_a: assert property ($changed(flags_o) |-> $past(nvm_done_i) || $past(srst_i, 2) || $past(srst_i, 3))
    else $error("flags changed without a store write");
  arb_state_a: assert property (goto_arb_o |-> !($past(tag_state_i) inside {rgd_pkg::TAG_READY, rgd_pkg::TAG_KILLED}))
    else $error("arbitrate request from ready or killed");
  req_state_a: assert property ($rose(nvm_o.req) |-> $past(tag_state_i) inside {rgd_pkg::TAG_OPEN, rgd_pkg::TAG_SECURED})
    else $error("store write outside open or secured");
  tx_end_a: assert property (tx_o.valid && tx_o.last && tx_ready_i |=> !tx_o.valid)
    else $error("reply runs past its last bit");
  cover property ($rose(tx_o.valid));
  cover property (goto_arb_o);
  cover property (apb_o.pready && apb_o.pslverr);
endmodule : rgd_cmd_sva
bind rgd_cmd rgd_cmd_sva rgd_cmd_sva_inst (
  .clk_i(clk_i), .srst_i(srst_i), .apb_i(apb_i), .apb_o(apb_o), .tag_state_i(tag_state_i),
  .tx_o(tx_o), .tx_ready_i(tx_ready_i), .nvm_o(nvm_o), .nvm_done_i(nvm_done_i),
  .goto_arb_o(goto_arb_o), .flags_o(flags_o)
);
`default_nettype wire

//--- testbench/rgd_far_end.sv
// store and modulator stand-in on the tag side of the handler
`timescale 1ns/10ps
`default_nettype none
module rgd_far_end (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // store side
  input wire rgd_pkg::rgd_nvm_req_t nvm_i,
  input wire logic slow_i,
  input wire logic fail_i,
  output logic done_o,
  output logic err_o,
  // modulator side
  output logic ready_o
);
  logic [2:0] wait_r;
  logic [1:0] ph_r;
  logic hit;
  always_ff @(posedge clk_i) begin
    if (srst_i || !nvm_i.req) begin
      wait_r <= 3'h0;
    end else if (wait_r != 3'h7) begin
      wait_r <= wait_r + 3'h1;
    end
    ph_r <= (srst_i || ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
  end
  // one answer per write, prompt or late
  assign hit = nvm_i.req && wait_r == (slow_i ? 3'h6 : 3'h1);
  assign done_o = hit && !fail_i;
  assign err_o = hit && fail_i;
  // a stall every third clock so the reply must wait
  assign ready_o = ph_r != 2'h2;
endmodule : rgd_far_end
`default_nettype wire

//--- testbench/tb_rgd_cmd.sv
// self-checking bench for the guard and alarm command handler
`timescale 1ns/10ps
`default_nettype none
module tb_rgd_cmd;
  localparam logic [31:0] PW = 32'hC0DE_5EED;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  rgd_pkg::rgd_apb_req_t req = '0;
  rgd_pkg::rgd_apb_rsp_t rsp;
  rgd_pkg::rgd_rx_t rx = '0;
  rgd_pkg::rgd_tag_state_t st = rgd_pkg::TAG_SECURED;
  rgd_pkg::rgd_tx_t tx;
  rgd_pkg::rgd_nvm_req_t nvm;
  rgd_pkg::rgd_flags_t flags;
  rgd_pkg::rgd_flags_t nfl = 3'h7;
  logic [15:0] hnd = 16'hA5C3;
  logic [15:0] rn = 16'h1234;
  logic rq = 1'b1;
  logic fail = 1'b0;
  logic slow = 1'b0;
  logic rdy, done, err, arb, aq, e;
  logic [31:0] q;
  logic [63:0] rbits = '0;
  int rcnt = 0;
  int acnt = 0;
  int bad_count = 0;
  int total_checks = 0;

  rgd_cmd #(.TIMEOUT_CYC(50)) rgd_cmd_inst (
    .clk_i(clk_i), .srst_i(srst_i), .apb_i(req), .apb_o(rsp), .rx_i(rx), .tag_state_i(st),
    .handle_i(hnd), .rn16_i(rn), .reqrn_i(rq), .tx_o(tx), .tx_ready_i(rdy), .nvm_o(nvm),
    .nvm_done_i(done), .nvm_err_i(err), .nvm_flags_i(nfl), .goto_arb_o(arb), .flags_o(flags),
    .alarm_query_en_o(aq)
  );
  rgd_far_end rgd_far_end_inst (
    .clk_i(clk_i), .srst_i(srst_i), .nvm_i(nvm), .slow_i(slow), .fail_i(fail),
    .done_o(done), .err_o(err), .ready_o(rdy)
  );

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // reply bits are collected only when the modulator takes them
  always @(posedge clk_i) begin
    if (tx.valid && rdy) begin
      rbits <= {rbits[62:0], tx.data};
      rcnt <= rcnt + 1;
    end
    if (arb) begin
      acnt <= acnt + 1;
    end
  end

  task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
    total_checks++;
    if (g !== x) begin
      $display("FAIL %s expected %h seen %h", nm, x, g);
      bad_count++;
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  function automatic logic [15:0] crc(input logic [79:0] d, input int n);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = n - 1; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction : crc

  // clear frame: opcode, scrambled password, handle, crc
  function automatic logic [79:0] fclr(input logic [31:0] pw);
    logic [63:0] b;
    b = {rgd_pkg::OP_CLEAR_GUARD, pw ^ {rn, rn}, hnd};
    return {b, ~crc(80'(b), 64)};
  endfunction : fclr

  // alarm frame: opcode, action, handle, crc (flip spoils the crc)
  function automatic logic [79:0] falm(input logic act, input logic [15:0] hh, input logic [15:0] flip);
    logic [32:0] b;
    b = {rgd_pkg::OP_SET_ALARM, act, hh};
    return 80'({b, ~crc(80'(b), 33) ^ flip});
  endfunction : falm

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.pready !== 1'b1);
    chk("apb wait cycles", 64'h2, 64'(n));
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    @(posedge clk_i);
  endtask : apb

  // sends one frame, then watches a window long enough for the slowest reply
  task automatic cmd(input logic [79:0] f, input int n, input rgd_pkg::rgd_tag_state_t s, input logic fs,
                     input int el, input int ea);
    int r0;
    int a0;
    r0 = rcnt;
    a0 = acnt;
    st <= s;
    rx <= '{sof: 1'b1, fsync: fs, valid: 1'b0, data: 1'b0, eof: 1'b0};
    @(posedge clk_i);
    rx.sof <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk_i);
      rx.valid <= 1'b1;
      rx.data <= f[i];
      @(posedge clk_i);
      rx.valid <= 1'b0;
    end
    @(posedge clk_i);
    rx.eof <= 1'b1;
    @(posedge clk_i);
    rx.eof <= 1'b0;
    repeat (150) @(posedge clk_i);
    chk("reply bits", 64'(el), 64'(rcnt - r0));
    chk("arbitrate pulses", 64'(ea), 64'(acnt - a0));
    if (el == 33) chk("ok reply", 64'({1'b0, hnd, ~crc(80'({1'b0, hnd}), 17)}), 64'(rbits[32:0]));
    if (el == 41) chk("error reply", 64'({1'b1, rgd_pkg::ERR_CODE_GENERIC, hnd,
      ~crc(80'({1'b1, rgd_pkg::ERR_CODE_GENERIC, hnd}), 25)}), 64'(rbits[40:0]));
  endtask : cmd

  initial begin
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("flags after power-up", 64'h7, 64'(flags));
    chk("alarm query enable", 64'h1, 64'(aq));
    apb(1'b0, rgd_pkg::REG_CONFIG, '0);
    chk("config word", 64'h0000_E000, 64'(q));
    apb(1'b0, 8'h10, '0);
    chk("unmapped error", 64'h1, 64'(e));
    $display("test reset done");
    cmd(fclr(PW), 80, rgd_pkg::TAG_SECURED, 1'b1, 0, 0);
    apb(1'b1, rgd_pkg::REG_ACCESS_PW, PW);
    apb(1'b0, rgd_pkg::REG_ACCESS_PW, '0);
    chk("password register", 64'(PW), 64'(q));
    cmd(fclr(PW ^ 32'h0000_0001), 80, rgd_pkg::TAG_SECURED, 1'b1, 0, 1);
    cmd(fclr(PW), 80, rgd_pkg::TAG_SECURED, 1'b0, 0, 0);
    rq <= 1'b0;
    cmd(fclr(PW), 80, rgd_pkg::TAG_SECURED, 1'b1, 0, 0);
    rq <= 1'b1;
    slow <= 1'b1;
    cmd(fclr(PW), 80, rgd_pkg::TAG_OPEN, 1'b1, 33, 0);
    chk("guards cleared", 64'h4, 64'(flags));
    apb(1'b0, rgd_pkg::REG_CONFIG, '0);
    chk("config after clear", 64'h0000_8000, 64'(q));
    $display("test clear done");
    slow <= 1'b0;
    cmd(falm(1'b0, hnd, 16'h0000), 49, rgd_pkg::TAG_OPEN, 1'b1, 0, 0);
    cmd(falm(1'b0, hnd, 16'h0000), 49, rgd_pkg::TAG_ARBITRATE, 1'b1, 0, 1);
    cmd(falm(1'b0, hnd, 16'h0000), 49, rgd_pkg::TAG_KILLED, 1'b1, 0, 0);
    cmd(falm(1'b0, hnd, 16'h0001), 49, rgd_pkg::TAG_SECURED, 1'b1, 0, 0);
    cmd(falm(1'b0, ~hnd, 16'h0000), 49, rgd_pkg::TAG_SECURED, 1'b1, 0, 0);
    cmd(falm(1'b0, hnd, 16'h0000), 49, rgd_pkg::TAG_SECURED, 1'b1, 33, 0);
    chk("alarm cleared", 64'h0, 64'(flags));
    chk("query until power-up", 64'h1, 64'(aq));
    fail <= 1'b1;
    cmd(falm(1'b1, hnd, 16'h0000), 49, rgd_pkg::TAG_SECURED, 1'b1, 41, 0);
    chk("flags kept on error", 64'h0, 64'(flags));
    fail <= 1'b0;
    cmd(falm(1'b1, hnd, 16'h0000), 49, rgd_pkg::TAG_SECURED, 1'b1, 33, 0);
    chk("alarm set", 64'h4, 64'(flags));
    apb(1'b1, rgd_pkg::REG_ACCESS_PW, 32'h0000_0000);
    cmd(falm(1'b0, hnd, 16'h0000), 49, rgd_pkg::TAG_SECURED, 1'b1, 0, 0);
    apb(1'b0, rgd_pkg::REG_STATUS, '0);
    chk("status counts", 64'h0301_0A03, 64'(q));
    $display("test alarm done");
    nfl <= 3'h0;
    srst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("query after power-up", 64'h0, 64'(aq));
    $display("test power-up done");
    finish_test();
  end

  // the whole run needs well under a millisecond
  initial begin
    #1_000_000;
    bad_count++;
    finish_test();
  end
endmodule : tb_rgd_cmd
`default_nettype wire
